// *** design/adc_serial_output_port.sv ***
// Design decisions made here: register access over APB and the register addresses.
`timescale 1ns/1ps
module adc_serial_output_port
    import adc_port_pkg::*;
(
    input  wire logic     pclk,
    input  wire logic     presetn,
    input  wire apb_req_s apb,
    output logic [31:0]   prdata,
    output logic          pready,
    output logic          pslverr,
    input  wire logic     master_clock_in,
    input  wire logic     convert_request,
    input  wire logic     calibrate,
    input  wire logic     channel_select,
    input  wire logic     polarity_mode,
    input  wire logic     port_select_n,
    input  wire logic     shift_clock,
    output logic          word_ready_n,
    output logic          serial_out,
    output logic          serial_out_oe
);

    function automatic logic [2:0] reg_index(input logic [7:0] addr);
        if (addr == CH1_IN_OFS) begin
            reg_index = 3'd0;
        end else if (addr == CH2_IN_OFS) begin
            reg_index = 3'd1;
        end else if (addr == STATUS_OFS) begin
            reg_index = 3'd2;
        end else if (addr == WORD_OFS) begin
            reg_index = 3'd3;
        end else if (addr == CAL_OFS) begin
            reg_index = 3'd4;
        end else begin
            reg_index = 3'd7;
        end
    endfunction

    // pin synchronisers; edges are taken from the second and third stages
    logic [6:0] pin_meta_r;
    logic [6:0] pin_sync_r;
    logic [6:0] pin_prev_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_meta_r <= 7'h60;
            pin_sync_r <= 7'h60;
            pin_prev_r <= 7'h60;
        end else begin
            pin_meta_r <= {shift_clock, port_select_n, polarity_mode,
                           channel_select, calibrate, convert_request,
                           master_clock_in};
            pin_sync_r <= pin_meta_r;
            pin_prev_r <= pin_sync_r;
        end
    end

    logic mclk_rise;
    logic convert_request_rise;
    logic sel_n;

    assign mclk_rise = pin_sync_r[PIN_MCLK] & ~pin_prev_r[PIN_MCLK];
    assign convert_request_rise = pin_sync_r[PIN_CONVERT_REQUEST] & ~pin_prev_r[PIN_CONVERT_REQUEST];
    // select takes two pclk to land; host's setup time covers it
    assign sel_n     = pin_sync_r[PIN_CSN];

    // conversion sequencer and filter
    convert_request_state_e state_r, state_nxt;
    logic [10:0] cnt_r, cnt_nxt;
    logic        phase_r, phase_nxt;
    logic [28:0] acc_r, acc_nxt;
    logic        chan_r, chan_nxt;
    logic [19:0] word_r, word_nxt;
    logic [19:0] cal_offset_r, cal_offset_nxt;
    logic        rdy_n_r, rdy_n_nxt;
    logic [19:0] ch_in_r [2];
    logic [19:0] ch_in_nxt [2];
    logic [31:0] prdata_r, prdata_nxt;
    logic        slverr_r, slverr_nxt;

    port_ctl_s   port_ctl;
    logic        port_load;
    port_stat_s  port_stat;
    logic        mod_strobe;
    logic        update;
    logic [19:0] sample;
    logic [19:0] avg;
    logic [2:0]  idx;

    always_comb begin
        state_nxt      = state_r;
        cnt_nxt        = cnt_r;
        phase_nxt      = phase_r;
        acc_nxt        = acc_r;
        chan_nxt       = chan_r;
        word_nxt       = word_r;
        cal_offset_nxt = cal_offset_r;
        rdy_n_nxt      = rdy_n_r;
        update         = 1'b0;
        port_load      = 1'b0;
        mod_strobe     = mclk_rise & phase_r;
        // calibration measures the raw input, conversion removes it
        sample = (chan_r ? ch_in_r[1] : ch_in_r[0])
                 - ((state_r == CONVERTING) ? cal_offset_r : 20'h00000);
        if (port_stat.emptied) begin
            rdy_n_nxt = 1'b1;
        end
        case (state_r)
            IDLE: begin
                if (convert_request_rise) begin
                    chan_nxt  = pin_sync_r[PIN_CHAN];
                    cnt_nxt   = 11'd0;
                    phase_nxt = 1'b0;
                    acc_nxt   = 29'h0;
                    state_nxt = pin_sync_r[PIN_CAL] ? CALIBRATING
                                                    : CONVERTING;
                end
            end
            CONVERTING, CALIBRATING: begin
                if (mclk_rise) begin
                    cnt_nxt   = cnt_r + 11'd1;
                    phase_nxt = ~phase_r;
                end
                // boxcar over whole modulator samples: symmetric taps give
                // linear phase, and its zeros track the master clock
                if (mod_strobe && cnt_r >= ACC_START) begin
                    acc_nxt = acc_r + {9'h000, sample};
                end
                if (state_r == CONVERTING && mclk_rise
                    && cnt_nxt == CONVERT_REQUEST_CYCLES - PRE_UPDATE_LEAD) begin
                    rdy_n_nxt = 1'b1;
                end
                if (mclk_rise && cnt_nxt == CONVERT_REQUEST_CYCLES) begin
                    update = 1'b1;
                end
            end
            default: begin
                state_nxt = IDLE;
            end
        endcase
        avg = acc_nxt[28:AVG_SHIFT];
        if (update) begin
            if (state_r == CONVERTING) begin
                // corner and notch depths follow from the boxcar length
                word_nxt = pin_sync_r[PIN_POL] ? (avg ^ MID_SCALE)
                                               : avg;
                if (!port_stat.full || sel_n) begin
                    port_load     = 1'b1;
                    rdy_n_nxt     = 1'b0;
                end
            end else begin
                cal_offset_nxt = avg;
            end
            if (state_r == CONVERTING && pin_sync_r[PIN_CONVERT_REQUEST]
                && !pin_sync_r[PIN_CAL]) begin
                cnt_nxt   = 11'd0;
                phase_nxt = 1'b0;
                acc_nxt   = 29'h0;
            end else begin
                state_nxt = IDLE;
            end
        end
    end

    logic sclk_rise;
    logic sclk_fall;

    assign sclk_rise = pin_sync_r[PIN_SCLK] & ~pin_prev_r[PIN_SCLK];
    assign sclk_fall = ~pin_sync_r[PIN_SCLK] & pin_prev_r[PIN_SCLK];
    // whole struct from one assign, the load bit comes from the comb block
    assign port_ctl  = '{load: port_load, word: word_nxt, cs_n: sel_n,
                         sclk_rise: sclk_rise, sclk_fall: sclk_fall};

    // apb slave: zero wait, read data captured during the setup phase
    always_comb begin
        ch_in_nxt[0] = ch_in_r[0];
        ch_in_nxt[1] = ch_in_r[1];
        prdata_nxt   = prdata_r;
        slverr_nxt   = slverr_r;
        idx          = reg_index(apb.paddr);
        if (apb.psel && !apb.penable) begin
            slverr_nxt = (idx == 3'd7);
            if (idx == 3'd0) begin
                prdata_nxt = {12'h000, ch_in_r[0]};
            end else if (idx == 3'd1) begin
                prdata_nxt = {12'h000, ch_in_r[1]};
            end else if (idx == 3'd2) begin
                prdata_nxt = {24'h000000, state_r != IDLE,
                              state_r == CALIBRATING, chan_r,
                              pin_sync_r[PIN_POL], port_stat.full,
                              port_stat.presenting, port_stat.armed,
                              rdy_n_r};
            end else if (idx == 3'd3) begin
                prdata_nxt = {12'h000, word_r};
            end else if (idx == 3'd4) begin
                prdata_nxt = {12'h000, cal_offset_r};
            end else begin
                prdata_nxt = 32'h00000000;
            end
        end
        if (apb.psel && apb.penable && apb.pwrite) begin
            if (idx == 3'd0) begin
                ch_in_nxt[0] = apb.pwdata[19:0];
            end else if (idx == 3'd1) begin
                ch_in_nxt[1] = apb.pwdata[19:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r      <= IDLE;
            cnt_r        <= 11'd0;
            phase_r      <= 1'b0;
            acc_r        <= 29'h0;
            chan_r       <= 1'b0;
            word_r       <= WORD_RESET;
            cal_offset_r <= WORD_RESET;
            rdy_n_r      <= 1'b1;
            ch_in_r[0]   <= WORD_RESET;
            ch_in_r[1]   <= WORD_RESET;
            prdata_r     <= 32'h00000000;
            slverr_r     <= 1'b0;
        end else begin
            state_r      <= state_nxt;
            cnt_r        <= cnt_nxt;
            phase_r      <= phase_nxt;
            acc_r        <= acc_nxt;
            chan_r       <= chan_nxt;
            word_r       <= word_nxt;
            cal_offset_r <= cal_offset_nxt;
            rdy_n_r      <= rdy_n_nxt;
            ch_in_r[0]   <= ch_in_nxt[0];
            ch_in_r[1]   <= ch_in_nxt[1];
            prdata_r     <= prdata_nxt;
            slverr_r     <= slverr_nxt;
        end
    end

    assign prdata       = prdata_r;
    assign pslverr      = slverr_r & apb.psel & apb.penable;
    assign pready       = 1'b1;
    assign word_ready_n = rdy_n_r;

    serial_out_port u_port (
        .pclk          (pclk),
        .presetn       (presetn),
        .ctl           (port_ctl),
        .serial_out    (serial_out),
        .serial_out_oe (serial_out_oe),
        .stat          (port_stat)
    );

    // independent count of master edges since the run began
    logic [10:0] edge_cnt_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            edge_cnt_r <= 11'd0;
        end else if (state_r == IDLE || (update && state_nxt != IDLE)) begin
            edge_cnt_r <= 11'd0;
        end else if (mclk_rise) begin
            edge_cnt_r <= edge_cnt_r + 11'd1;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_CONVERT_REQUEST_LEN: assert property (
        update |-> mclk_rise && edge_cnt_r == CONVERT_REQUEST_CYCLES - 11'd1)
        else $error("update not at end of conversion");
    AST_RDY_PRE: assert property (
        state_r == CONVERTING && mclk_rise
        && edge_cnt_r == CONVERT_REQUEST_CYCLES - PRE_UPDATE_LEAD - 11'd1
        |=> word_ready_n)
        else $error("ready flag not raised before update");
    AST_DISCARD: assert property (
        update && port_stat.full && !sel_n |-> !port_ctl.load)
        else $error("word loaded into a busy selected port");
    AST_RDY_LOW: assert property (
        port_ctl.load |=> !word_ready_n ##1 port_stat.full)
        else $error("ready flag not low after load");
    AST_CH_LATCH: assert property (
        state_r == IDLE && convert_request_rise
        |=> chan_r == $past(pin_sync_r[PIN_CHAN]))
        else $error("channel not latched on convert rise");
    AST_START: assert property (
        state_r == IDLE && convert_request_rise |=>
        state_r == ($past(pin_sync_r[PIN_CAL]) ? CALIBRATING : CONVERTING))
        else $error("wrong run started on convert rise");
    AST_CONT: assert property (
        update && state_r == CONVERTING && pin_sync_r[PIN_CONVERT_REQUEST]
        && !pin_sync_r[PIN_CAL] |=> state_r == CONVERTING && cnt_r == 11'd0)
        else $error("continuous conversion did not restart");
    AST_EMPTY_RDY: assert property (
        port_stat.emptied && !port_ctl.load |=> word_ready_n)
        else $error("ready flag not raised after lsb");

endmodule

// *** common/adc_port_pkg.sv ***
package adc_port_pkg;

    localparam int          WORD_BITS       = 20;
    localparam int          AVG_SHIFT       = 9;
    localparam logic [10:0] CONVERT_REQUEST_CYCLES     = 11'd1624;
    localparam logic [10:0] PRE_UPDATE_LEAD = 11'd2;
    // boxcar covers the last 2**AVG_SHIFT modulator samples
    localparam logic [10:0] ACC_START       = 11'd600;
    localparam logic [19:0] MID_SCALE       = 20'h80000;
    localparam logic [19:0] WORD_RESET      = 20'h00000;
    localparam logic [4:0]  MSB_INDEX       = 5'd19;

    localparam logic [7:0]  CH1_IN_OFS      = 8'h00;
    localparam logic [7:0]  CH2_IN_OFS      = 8'h04;
    localparam logic [7:0]  STATUS_OFS      = 8'h08;
    localparam logic [7:0]  WORD_OFS        = 8'h0c;
    localparam logic [7:0]  CAL_OFS         = 8'h10;

    localparam int          PIN_MCLK        = 0;
    localparam int          PIN_CONVERT_REQUEST        = 1;
    localparam int          PIN_CAL         = 2;
    localparam int          PIN_CHAN        = 3;
    localparam int          PIN_POL         = 4;
    localparam int          PIN_CSN         = 5;
    localparam int          PIN_SCLK        = 6;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } apb_req_s;

    typedef struct packed {
        logic        load;
        logic [19:0] word;
        logic        cs_n;
        logic        sclk_rise;
        logic        sclk_fall;
    } port_ctl_s;

    typedef struct packed {
        logic full;
        logic presenting;
        logic armed;
        logic emptied;
    } port_stat_s;

    typedef enum logic [1:0] {
        IDLE,
        CONVERTING,
        CALIBRATING
    } convert_request_state_e;

endpackage

// *** design/serial_out_port.sv ***
`timescale 1ns/1ps
module serial_out_port
    import adc_port_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire port_ctl_s  ctl,
    output logic            serial_out,
    output logic            serial_out_oe,
    output port_stat_s      stat
);

    logic [19:0] shreg_r, shreg_nxt;
    logic [4:0]  idx_r, idx_nxt;
    logic        full_r, full_nxt;
    logic        armed_r, armed_nxt;
    logic        oe_r, oe_nxt;
    logic        emptied_r, emptied_nxt;
    logic        out_r, out_nxt;

    always_comb begin
        shreg_nxt   = shreg_r;
        idx_nxt     = idx_r;
        full_nxt    = full_r;
        armed_nxt   = armed_r;
        oe_nxt      = oe_r;
        emptied_nxt = 1'b0;
        if (ctl.load) begin
            shreg_nxt = ctl.word;
            idx_nxt   = MSB_INDEX;
            full_nxt  = 1'b1;
            armed_nxt = 1'b0;
            oe_nxt    = 1'b0;
        end else if (ctl.cs_n || !full_r) begin
            // deselect mid-word keeps the bit position but disarms
            oe_nxt    = 1'b0;
            armed_nxt = 1'b0;
        end else begin
            oe_nxt = 1'b1;
            if (oe_r && !armed_r && ctl.sclk_rise) begin
                armed_nxt = 1'b1;
            end else if (oe_r && armed_r && ctl.sclk_fall) begin
                if (idx_r == 5'd0) begin
                    oe_nxt      = 1'b0;
                    full_nxt    = 1'b0;
                    armed_nxt   = 1'b0;
                    emptied_nxt = 1'b1;
                end else begin
                    idx_nxt = idx_r - 5'd1;
                end
            end
            // a fall before arming is dropped here
        end
        out_nxt = shreg_nxt[idx_nxt];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shreg_r   <= WORD_RESET;
            idx_r     <= MSB_INDEX;
            full_r    <= 1'b0;
            armed_r   <= 1'b0;
            oe_r      <= 1'b0;
            emptied_r <= 1'b0;
            out_r     <= 1'b0;
        end else begin
            shreg_r   <= shreg_nxt;
            idx_r     <= idx_nxt;
            full_r    <= full_nxt;
            armed_r   <= armed_nxt;
            oe_r      <= oe_nxt;
            emptied_r <= emptied_nxt;
            out_r     <= out_nxt;
        end
    end

    assign serial_out      = out_r;
    assign serial_out_oe   = oe_r;
    // one driver for the whole struct
    assign stat = '{full: full_r, presenting: oe_r, armed: armed_r,
                    emptied: emptied_r};

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_PRESENT: assert property (
        !ctl.cs_n && full_r && !ctl.load
        && !(oe_r && armed_r && ctl.sclk_fall && idx_r == 5'd0)
        |=> serial_out_oe)
        else $error("selected full port not driving output");
    AST_NO_EARLY_FALL: assert property (
        oe_r && !armed_r && ctl.sclk_fall && !ctl.cs_n && !ctl.load
        |=> $stable(idx_r))
        else $error("unarmed falling edge advanced the shifter");
    AST_LSB_END: assert property (
        oe_r && armed_r && ctl.sclk_fall && idx_r == 5'd0
        && !ctl.cs_n && !ctl.load
        |=> !serial_out_oe && !full_r && emptied_r)
        else $error("port not emptied after lsb");
    AST_DESEL: assert property (
        ctl.cs_n |=> !serial_out_oe)
        else $error("output driven while deselected");
    AST_MSB_FIRST: assert property (
        ctl.load |=> idx_r == MSB_INDEX && full_r ##0
        serial_out == shreg_r[19])
        else $error("load did not present msb");

endmodule

// *** tb/host_port.sv ***
`timescale 1ns/1ps
module host_port (
    input  wire logic pclk,
    input  wire logic serial_out,
    input  wire logic serial_out_oe,
    output logic      port_select_n = 1'b1,
    output logic      shift_clock = 1'b0
);
    logic last_r = 1'b0;
    logic line;
    // released line shows the inverse of the last driven bit
    always @(posedge pclk) if (serial_out_oe) last_r <= serial_out;
    assign line = serial_out_oe ? serial_out : ~last_r;

    task automatic set_sclk(input logic v);
        @(posedge pclk);
        shift_clock <= v;
        // each phase well above the 3 pclk the pins need to sync
        repeat (6) @(posedge pclk);
    endtask

    task automatic select(input logic v);
        @(posedge pclk);
        port_select_n <= v;
    endtask

    task automatic read_word(input logic pre_high, output logic [19:0] w,
                             output logic oe0, output logic oe1);
        if (pre_high) set_sclk(1'b1);
        select(1'b0);
        repeat (30) @(posedge pclk);
        oe0 = serial_out_oe;
        if (pre_high) set_sclk(1'b0);
        w[19] = line;
        for (int i = 18; i >= 0; i--) begin
            set_sclk(1'b1);
            set_sclk(1'b0);
            w[i] = line;
        end
        set_sclk(1'b1);
        set_sclk(1'b0);
        oe1 = serial_out_oe;
        select(1'b1);
    endtask
endmodule

// *** tb/tb.sv ***
`timescale 1ns/1ps
module tb
    import adc_port_pkg::*;
;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        master_clock_in = 1'b0;
    logic        convert_request = 1'b0;
    logic        calibrate = 1'b0;
    logic        channel_select = 1'b0;
    logic        polarity_mode = 1'b0;
    apb_req_s    apb_q = '0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        port_select_n;
    logic        shift_clock;
    logic        word_ready_n;
    logic        serial_out;
    logic        serial_out_oe;
    int          errors = 0;
    int          num_checks = 0;
    int          mrises = 0;

    adc_serial_output_port dut (
        .pclk(pclk), .presetn(presetn), .apb(apb_q), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .master_clock_in(master_clock_in),
        .convert_request(convert_request), .calibrate(calibrate),
        .channel_select(channel_select), .polarity_mode(polarity_mode),
        .port_select_n(port_select_n), .shift_clock(shift_clock),
        .word_ready_n(word_ready_n), .serial_out(serial_out),
        .serial_out_oe(serial_out_oe)
    );

    host_port host (
        .pclk(pclk), .serial_out(serial_out),
        .serial_out_oe(serial_out_oe), .port_select_n(port_select_n),
        .shift_clock(shift_clock)
    );

    initial forever #10 pclk = ~pclk;
    // offset keeps master edges clear of pclk edges
    initial begin
        #7;
        forever #80 master_clock_in = ~master_clock_in;
    end
    always @(posedge master_clock_in) mrises <= mrises + 1;

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        repeat (80000) @(posedge pclk);
        errors++;
        $display("mismatch timeout exp done got hang");
        tally_and_finish();
    end

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s exp %h got %h", what, exp, got);
        end
    endtask

    task automatic chk_bit(input string what, input logic exp,
                           input logic got);
        chk(what, {31'h0, exp}, {31'h0, got});
    endtask

    task automatic apb_xfer(input logic wr, input logic [7:0] a,
                            input logic [31:0] d, output logic [31:0] rd,
                            output logic err);
        @(posedge pclk);
        apb_q <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a,
                   pwdata: d};
        @(posedge pclk);
        apb_q.penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        apb_q <= '0;
    endtask

    task automatic set_input(input logic [7:0] a, input logic [19:0] v);
        logic [31:0] rd;
        logic        err;
        apb_xfer(1'b1, a, {12'h0, v}, rd, err);
        apb_xfer(1'b0, a, 32'h0, rd, err);
        chk("input readback", {12'h0, v}, rd);
    endtask

    // master rises since c0 when the ready flag next changes
    task automatic wait_ready(input int c0, output int cnt);
        logic start;
        int   n;
        start = word_ready_n;
        n = 0;
        while (word_ready_n === start && n < 20000) begin
            @(posedge pclk);
            n++;
        end
        cnt = mrises - c0;
    endtask

    // counts master rises from the convert rise to the next ready change
    task automatic convert(input logic ch, input logic pol, input logic hold,
                           output int cnt);
        int c0;
        @(posedge pclk);
        channel_select <= ch;
        polarity_mode <= pol;
        @(negedge master_clock_in);
        @(posedge pclk);
        convert_request <= 1'b1;
        c0 = mrises;
        repeat (10) @(posedge pclk);
        convert_request <= hold;
        channel_select <= ~ch;
        wait_ready(c0, cnt);
    endtask

    task automatic t_regs();
        logic [31:0] rd;
        logic        err;
        chk_bit("ready at reset", 1'b1, word_ready_n);
        chk_bit("oe at reset", 1'b0, serial_out_oe);
        chk_bit("pready", 1'b1, pready);
        apb_xfer(1'b0, STATUS_OFS, 32'h0, rd, err);
        chk("status reset", 32'h00000001, rd);
        apb_xfer(1'b1, WORD_OFS, 32'hffffffff, rd, err);
        apb_xfer(1'b0, WORD_OFS, 32'h0, rd, err);
        chk("word read only", 32'h0, rd);
        apb_xfer(1'b0, 8'h20, 32'h0, rd, err);
        chk_bit("unmapped error", 1'b1, err);
        chk("unmapped data", 32'h0, rd);
        repeat (3) begin
            host.set_sclk(1'b1);
            host.set_sclk(1'b0);
        end
        chk_bit("oe deselected", 1'b0, serial_out_oe);
        $display("test regs done");
    endtask

    task automatic t_unipolar();
        int          cnt;
        logic [19:0] w;
        logic        oe0;
        logic        oe1;
        set_input(CH1_IN_OFS, 20'h12345);
        convert(1'b0, 1'b0, 1'b0, cnt);
        chk("load delay", 32'(cnt), 32'd1624);
        chk_bit("oe before select", 1'b0, serial_out_oe);
        host.read_word(1'b0, w, oe0, oe1);
        chk_bit("oe on select", 1'b1, oe0);
        chk("word ch1", 32'h00012345, {12'h0, w});
        chk_bit("oe after lsb", 1'b0, oe1);
        chk_bit("ready after lsb", 1'b1, word_ready_n);
        $display("test unipolar done");
    endtask

    task automatic t_bipolar();
        int          cnt;
        logic [19:0] w;
        logic        oe0;
        logic        oe1;
        set_input(CH2_IN_OFS, 20'h00abc);
        convert(1'b1, 1'b1, 1'b0, cnt);
        chk("load delay ch2", 32'(cnt), 32'd1624);
        host.read_word(1'b1, w, oe0, oe1);
        chk("word ch2", {12'h0, 20'h00abc ^ MID_SCALE}, {12'h0, w});
        chk_bit("oe after lsb", 1'b0, oe1);
        $display("test bipolar done");
    endtask

    task automatic t_discard();
        int          cnt;
        int          c0;
        logic [19:0] w;
        logic        oe0;
        logic        oe1;
        set_input(CH1_IN_OFS, 20'h00111);
        // convert held high: the next run restarts at the load
        convert(1'b0, 1'b0, 1'b1, cnt);
        c0 = mrises;
        chk("load delay cont", 32'(cnt), 32'd1624);
        host.select(1'b0);
        set_input(CH1_IN_OFS, 20'h00222);
        wait_ready(c0, cnt);
        convert_request <= 1'b0;
        chk("pre-update lead", 32'(cnt), 32'd1622);
        repeat (40) @(posedge pclk);
        chk_bit("ready after discard", 1'b1, word_ready_n);
        host.read_word(1'b0, w, oe0, oe1);
        chk("kept word", 32'h00000111, {12'h0, w});
        $display("test discard done");
    endtask

    // runs last: the stored offset changes later conversions
    task automatic t_cal();
        logic [31:0] rd;
        logic        err;
        @(posedge pclk);
        calibrate <= 1'b1;
        channel_select <= 1'b1;
        repeat (4) @(posedge pclk);
        convert_request <= 1'b1;
        repeat (10) @(posedge pclk);
        convert_request <= 1'b0;
        calibrate <= 1'b0;
        apb_xfer(1'b0, STATUS_OFS, 32'h0, rd, err);
        chk("status in cal", 32'h000000e1, rd);
        repeat (13100) @(posedge pclk);
        chk_bit("ready after cal", 1'b1, word_ready_n);
        apb_xfer(1'b0, CAL_OFS, 32'h0, rd, err);
        chk("cal offset", 32'h00000abc, rd);
        $display("test cal done");
    endtask

    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        t_regs();
        t_unipolar();
        t_bipolar();
        t_discard();
        t_cal();
        tally_and_finish();
    end
endmodule
